// ===== hdl/mrx_consts.svh
// Purpose: Shared numeric constants of the MII / serial MII receive status block
// Assumes: Included by bare name from every design file that needs a figure
// Notes: Widths, positions, counts and clock rates; types live in the package
`ifndef MRX_CONSTS_SVH
`define MRX_CONSTS_SVH

// Serial group: ten bits per lane between two frame-sync pulses
`define MRX_GROUP_BITS 10
`define MRX_LAST_BIT 4'd9
`define MRX_FIRST_DONE 4'd1
`define MRX_CNT_ZERO 4'd0
`define MRX_CNT_W 4
// Number of serial lanes sharing the receive nibble pins
`define MRX_LANES 4
`define MRX_NIBBLE_W 4
// Link receive clock rate and core clock rate, in MHz
`define MRX_LINK_MHZ 125
`define MRX_CORE_MHZ 10
// Width of one captured group word (all lanes)
`define MRX_WORD_W 40

`endif

// ===== hdl/mrx_pkg.sv
// Purpose: Types of the MII / serial MII receive status block
// Assumes: mrx_consts.svh holds the numbers
// Notes: One-hot codes written out for the sink state machine
package mrx_pkg;

  typedef enum logic [1:0]
  {
    MRX_MODE_MII = 2'h1,
    MRX_MODE_SERIAL = 2'h2
  } mrx_mode_t;

  typedef enum logic [1:0]
  {
    MRX_SINK_WAIT = 2'h1,
    MRX_SINK_SHOW = 2'h2
  } mrx_sink_state_t;

endpackage

// ===== hdl/mrx_sync2.sv
// Purpose: Two-flop level synchroniser
// Assumes: Input is a level that holds long enough to be seen
// Notes: First stage is read by the second stage only
`timescale 1ns/1ps

module mrx_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync_out;

  always_comb
  begin
    next_stage1 = srst ? '0 : async_in;
    next_sync_out = srst ? '0 : stage1;
  end

  always_ff @(posedge clock)
  begin
    stage1 <= next_stage1;
    sync_out <= next_sync_out;
  end
endmodule // mrx_sync2

// ===== hdl/mrx_serial_rx.sv
// Purpose: Link-clock side of the serial receive path: group framing and word hand-off
// Assumes: link_rst is already synchronous to serial_receive_clock
// Notes: Hold word is written only while no hand-off is open, so the core reads it stable
`timescale 1ns/1ps
`include "mrx_consts.svh"

module mrx_serial_rx #(
  parameter int LANES = `MRX_LANES
) (
  input wire logic serial_receive_clock,
  input wire logic link_rst,
  input wire logic serial_mode,
  input wire logic frame_sync,
  input wire logic [LANES-1:0] serial_receive_lane,
  input wire logic ack_toggle,
  output logic req_toggle,
  output logic [LANES*`MRX_GROUP_BITS-1:0] hold_word,
  output logic hold_realigned,
  output logic hold_overrun
);
  logic [`MRX_CNT_W-1:0] bit_cnt;
  logic [`MRX_CNT_W-1:0] next_bit_cnt;
  logic aligned;
  logic next_aligned;
  logic [LANES*`MRX_GROUP_BITS-1:0] shift;
  logic [LANES*`MRX_GROUP_BITS-1:0] next_shift;
  logic misalign_seen;
  logic next_misalign_seen;
  logic overrun_seen;
  logic next_overrun_seen;
  logic next_req_toggle;
  logic [LANES*`MRX_GROUP_BITS-1:0] next_hold_word;
  logic next_hold_realigned;
  logic next_hold_overrun;
  logic ack_s;
  logic busy;
  logic done;
  logic early_sync;

  // Shift one bit into every lane; first bit received ends up in bit 0
  function automatic logic [LANES*`MRX_GROUP_BITS-1:0] shift_in(
    input logic [LANES*`MRX_GROUP_BITS-1:0] cur,
    input logic [LANES-1:0] bits
  );
    logic [LANES*`MRX_GROUP_BITS-1:0] res;
    res = cur;
    for (int i = 0; i < LANES; i++)
    begin
      res[i*`MRX_GROUP_BITS +: `MRX_GROUP_BITS] =
        {bits[i], cur[i*`MRX_GROUP_BITS+1 +: `MRX_GROUP_BITS-1]};
    end
    return res;
  endfunction

  mrx_sync2 #(.WIDTH(1)) u_ack_sync (
    .clock(serial_receive_clock),
    .srst(link_rst),
    .async_in(ack_toggle),
    .sync_out(ack_s)
  );

  always_comb
  begin
    busy = req_toggle ^ ack_s;
    early_sync = frame_sync && aligned && (bit_cnt != `MRX_CNT_ZERO);
    done = serial_mode && aligned && !frame_sync && (bit_cnt == `MRX_LAST_BIT);
    next_bit_cnt = bit_cnt;
    next_aligned = aligned;
    next_shift = shift;
    next_misalign_seen = misalign_seen;
    next_overrun_seen = overrun_seen;
    next_req_toggle = req_toggle;
    next_hold_word = hold_word;
    next_hold_realigned = hold_realigned;
    next_hold_overrun = hold_overrun;
    if (link_rst || !serial_mode)
    begin
      next_bit_cnt = `MRX_CNT_ZERO;
      next_aligned = 1'b0;
      next_misalign_seen = 1'b0;
      next_overrun_seen = 1'b0;
    end
    else
    begin
      // Lanes sampled on the rising edge of the link clock
      next_shift = shift_in(shift, serial_receive_lane);
      if (frame_sync)
      begin
        // Pulse marks bit 0 of a new group; partial group is dropped
        next_bit_cnt = `MRX_FIRST_DONE;
        next_aligned = 1'b1;
        if (early_sync)
        begin
          next_misalign_seen = 1'b1;
        end
      end
      else if (aligned)
      begin
        next_bit_cnt = (bit_cnt == `MRX_LAST_BIT) ? `MRX_CNT_ZERO :
          bit_cnt + `MRX_FIRST_DONE;
      end
      if (done)
      begin
        if (!busy)
        begin
          next_hold_word = next_shift;
          next_hold_realigned = misalign_seen;
          next_hold_overrun = overrun_seen;
          next_req_toggle = !req_toggle;
          next_misalign_seen = 1'b0;
          next_overrun_seen = 1'b0;
        end
        else
        begin
          // Core too slow to take this group; reported with the next one
          next_overrun_seen = 1'b1;
        end
      end
    end
    if (link_rst)
    begin
      next_req_toggle = 1'b0;
      next_hold_word = '0;
      next_hold_realigned = 1'b0;
      next_hold_overrun = 1'b0;
      next_shift = '0;
    end
  end

  always_ff @(posedge serial_receive_clock)
  begin
    bit_cnt <= next_bit_cnt;
    aligned <= next_aligned;
    shift <= next_shift;
    misalign_seen <= next_misalign_seen;
    overrun_seen <= next_overrun_seen;
    req_toggle <= next_req_toggle;
    hold_word <= next_hold_word;
    hold_realigned <= next_hold_realigned;
    hold_overrun <= next_hold_overrun;
  end

  a_sync_restart: assert property (@(posedge serial_receive_clock) disable iff (link_rst)
    (serial_mode && frame_sync) |=> (bit_cnt == `MRX_FIRST_DONE) && aligned)
    else $error("bit counter not realigned to frame sync");

  a_early_flag: assert property (@(posedge serial_receive_clock) disable iff (link_rst)
    (serial_mode && early_sync) |=> misalign_seen)
    else $error("early frame sync not flagged");

  a_lane_sample: assert property (@(posedge serial_receive_clock) disable iff (link_rst)
    (serial_mode && $past(serial_mode)) |->
      (shift[`MRX_GROUP_BITS-1] == $past(serial_receive_lane[0])))
    else $error("lane 0 not sampled on the link clock edge");

  a_group_ten: assert property (@(posedge serial_receive_clock) disable iff (link_rst)
    (serial_mode && frame_sync && !early_sync) ##1 (serial_mode && !frame_sync) [*8]
      ##1 (serial_mode && !frame_sync) |-> done)
    else $error("group not closed ten clocks after frame sync");

  c_group_done: cover property (@(posedge serial_receive_clock) disable iff (link_rst)
    done && !busy);
  c_overrun: cover property (@(posedge serial_receive_clock) disable iff (link_rst)
    done && busy);
endmodule // mrx_serial_rx

// ===== hdl/mrx_top.sv
// Purpose: Receive status inputs of one MAC port running as MII or as serial MII
// Assumes: serial_mode is a static level; link clock is free running in serial mode
// Notes: Core runs on clock; serial framing runs on serial_receive_clock
`timescale 1ns/1ps
`include "mrx_consts.svh"

module mrx_top (
  input wire logic clock,
  input wire logic srst,
  input wire logic serial_receive_clock,
  input wire mrx_pkg::mrx_mode_t port_mode,
  input wire logic port_b_receive_valid,
  input wire logic port_b_collision_in,
  input wire logic [`MRX_NIBBLE_W-1:0] port_b_receive_nibble,
  output mrx_pkg::mrx_mode_t active_mode,
  output logic [`MRX_NIBBLE_W-1:0] rx_nibble,
  output logic rx_nibble_valid,
  output logic collision,
  output logic collision_start,
  output logic [`MRX_WORD_W-1:0] group_data,
  output logic group_valid,
  output logic group_realigned,
  output logic group_overrun
);
  import mrx_pkg::*;

  // Core-domain copies of the pins
  logic valid_s;
  logic col_s;
  logic [`MRX_NIBBLE_W-1:0] nibble_s;
  logic serial_core_s;
  logic serial_link_s;
  logic link_rst;
  logic serial_mode_raw;
  logic req_s;
  logic req_seen;
  logic next_req_seen;
  logic req_toggle;
  logic [`MRX_WORD_W-1:0] hold_word;
  logic hold_realigned;
  logic hold_overrun;
  // Link-domain pin registers
  logic sync_pin;
  logic [`MRX_LANES-1:0] lane_pin;
  logic next_sync_pin;
  logic [`MRX_LANES-1:0] next_lane_pin;
  mrx_mode_t next_active_mode;
  logic [`MRX_NIBBLE_W-1:0] next_rx_nibble;
  logic next_rx_nibble_valid;
  logic next_collision;
  logic next_collision_start;
  logic [`MRX_WORD_W-1:0] next_group_data;
  logic next_group_valid;
  logic next_group_realigned;
  logic next_group_overrun;
  mrx_sink_state_t sink_state;
  mrx_sink_state_t next_sink_state;
  logic new_word;

  // Every decode of the mode input goes through here, so both domains agree
  function automatic logic is_serial(input mrx_mode_t mode);
    return (mode == MRX_MODE_SERIAL);
  endfunction

  // This port has no address hash or hash filter; frames leave unfiltered
  // Address filtering, if wanted, belongs to logic after this port

  assign serial_mode_raw = is_serial(port_mode);

  // MII pins and the mode level cross into the core clock
  // Pin to output is three core edges: two synchroniser stages and the output register
  mrx_sync2 #(.WIDTH(`MRX_NIBBLE_W + 3)) u_pin_sync (
    .clock(clock),
    .srst(srst),
    .async_in({serial_mode_raw, port_b_receive_valid, port_b_collision_in,
      port_b_receive_nibble}),
    .sync_out({serial_core_s, valid_s, col_s, nibble_s})
  );

  // Core reset and mode level cross into the link clock
  // The link side therefore leaves reset about two link clocks after the core
  mrx_sync2 #(.WIDTH(2)) u_link_sync (
    .clock(serial_receive_clock),
    .srst(1'b0),
    .async_in({srst, serial_mode_raw}),
    .sync_out({link_rst, serial_link_s})
  );

  // Request toggle from the link side, seen in the core domain
  mrx_sync2 #(.WIDTH(1)) u_req_sync (
    .clock(clock),
    .srst(srst),
    .async_in(req_toggle),
    .sync_out(req_s)
  );

  // The valid pin doubles as frame sync; it and the lanes are launched by the
  // PHY on the link clock, so one register stage on that clock aligns them
  always_comb
  begin
    next_sync_pin = link_rst ? 1'b0 : port_b_receive_valid;
    next_lane_pin = link_rst ? '0 : port_b_receive_nibble;
  end

  always_ff @(posedge serial_receive_clock)
  begin
    sync_pin <= next_sync_pin;
    lane_pin <= next_lane_pin;
  end

  mrx_serial_rx #(.LANES(`MRX_LANES)) u_serial_rx (
    .serial_receive_clock(serial_receive_clock),
    .link_rst(link_rst),
    .serial_mode(serial_link_s),
    .frame_sync(sync_pin),
    .serial_receive_lane(lane_pin),
    .ack_toggle(req_seen),
    .req_toggle(req_toggle),
    .hold_word(hold_word),
    .hold_realigned(hold_realigned),
    .hold_overrun(hold_overrun)
  );

  // MII receive path and collision status
  // Collision is a level; the start pulse lets the core count collision events
  always_comb
  begin
    next_active_mode = serial_core_s ? MRX_MODE_SERIAL : MRX_MODE_MII;
    next_rx_nibble = rx_nibble;
    next_rx_nibble_valid = 1'b0;
    next_collision = 1'b0;
    next_collision_start = 1'b0;
    if (!srst && !serial_core_s)
    begin
      if (valid_s)
      begin
        // Data only follows the pins while the PHY says it is valid
        next_rx_nibble = nibble_s;
        next_rx_nibble_valid = 1'b1;
      end
      // Collision level only counts in MII mode
      next_collision = col_s;
      next_collision_start = col_s && !collision;
    end
    // In serial mode the collision pin is not looked at
    if (srst)
    begin
      next_active_mode = MRX_MODE_MII;
      next_rx_nibble = '0;
    end
  end

  always_ff @(posedge clock)
  begin
    active_mode <= next_active_mode;
    rx_nibble <= next_rx_nibble;
    rx_nibble_valid <= next_rx_nibble_valid;
    collision <= next_collision;
    collision_start <= next_collision_start;
  end

  // Sink of the group hand-off: the toggle change means the hold word is stable
  // At full link rate a hand-off outlasts a group, so most groups are dropped
  // and reported as overrun; the core sees only one group in a few
  always_comb
  begin
    new_word = (req_s != req_seen);
    next_req_seen = req_seen;
    next_sink_state = sink_state;
    next_group_data = group_data;
    next_group_valid = 1'b0;
    next_group_realigned = group_realigned;
    next_group_overrun = group_overrun;
    unique case (sink_state)
      MRX_SINK_WAIT:
      begin
        if (new_word)
        begin
          next_group_data = hold_word;
          next_group_realigned = hold_realigned;
          next_group_overrun = hold_overrun;
          next_group_valid = 1'b1;
          next_sink_state = MRX_SINK_SHOW;
        end
      end
      MRX_SINK_SHOW:
      begin
        // Acknowledge only after the word is copied, so the link may refill
        next_req_seen = req_s;
        next_sink_state = MRX_SINK_WAIT;
      end
      default:
      begin
        next_sink_state = MRX_SINK_WAIT;
      end
    endcase
    if (srst)
    begin
      next_req_seen = 1'b0;
      next_sink_state = MRX_SINK_WAIT;
      next_group_data = '0;
      next_group_valid = 1'b0;
      next_group_realigned = 1'b0;
      next_group_overrun = 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    req_seen <= next_req_seen;
    sink_state <= next_sink_state;
    group_data <= next_group_data;
    group_valid <= next_group_valid;
    group_realigned <= next_group_realigned;
    group_overrun <= next_group_overrun;
  end

  a_valid_gate: assert property (@(posedge clock) disable iff (srst)
    (!serial_core_s && valid_s) |=> (rx_nibble_valid && rx_nibble == $past(nibble_s)))
    else $error("valid MII nibble not passed on");

  a_no_valid_idle: assert property (@(posedge clock) disable iff (srst)
    rx_nibble_valid |-> $past(valid_s) && !$past(serial_core_s))
    else $error("nibble marked valid without the valid input");

  a_collision_mii: assert property (@(posedge clock) disable iff (srst)
    (!serial_core_s && col_s) |=> collision ##1 (collision || !$past(col_s)))
    else $error("MII collision not reported");

  a_collision_off: assert property (@(posedge clock) disable iff (srst)
    serial_core_s |=> !collision && !collision_start)
    else $error("collision reported in serial mode");

  a_group_pulse: assert property (@(posedge clock) disable iff (srst)
    group_valid |=> !group_valid ##1 (req_seen == req_s || !group_valid))
    else $error("group pulse longer than one cycle");

  a_reset_quiet: assert property (@(posedge clock)
    srst |=> !rx_nibble_valid && !collision && !collision_start && !group_valid
      && (active_mode == MRX_MODE_MII))
    else $error("outputs not quiet after reset");

  // Nibble register only moves on a valid MII sample
  a_nibble_hold: assert property (@(posedge clock) disable iff (srst)
    (serial_core_s || !valid_s) |=> (rx_nibble == $past(rx_nibble)))
    else $error("nibble changed without the valid input");

  a_serial_quiet: assert property (@(posedge clock) disable iff (srst)
    serial_core_s |=> !rx_nibble_valid)
    else $error("MII nibble passed in serial mode");

  a_mode_follow: assert property (@(posedge clock) disable iff (srst)
    1'b1 |=> (is_serial(active_mode) == $past(serial_core_s)))
    else $error("active mode does not follow the mode input");

  a_col_clear: assert property (@(posedge clock) disable iff (srst)
    (!serial_core_s && !col_s) |=> !collision)
    else $error("collision shown without the collision input");

  a_start_edge: assert property (@(posedge clock) disable iff (srst)
    collision_start |-> collision && !$past(collision))
    else $error("collision start not on a rising collision");

  // Word and flags may only move together with the one-cycle group pulse
  a_group_hold: assert property (@(posedge clock) disable iff (srst)
    !group_valid |-> $stable(group_data))
    else $error("group word changed without a group pulse");

  a_flags_hold: assert property (@(posedge clock) disable iff (srst)
    !group_valid |-> $stable(group_realigned) && $stable(group_overrun))
    else $error("group flags changed without a group pulse");

  a_group_source: assert property (@(posedge clock) disable iff (srst)
    group_valid |-> $past(new_word) && ($past(sink_state) == MRX_SINK_WAIT))
    else $error("group pulse without a new hand-off word");

  a_handoff_ack: assert property (@(posedge clock) disable iff (srst)
    (sink_state == MRX_SINK_SHOW) |=> (req_seen == $past(req_s)))
    else $error("hand-off not acknowledged after the copy");

  // Pins are launched on the link clock, so one register stage is enough here
  a_pin_register: assert property (@(posedge serial_receive_clock)
    (!link_rst && !$past(link_rst)) |->
      (sync_pin == $past(port_b_receive_valid)) && (lane_pin == $past(port_b_receive_nibble)))
    else $error("link pins not registered on the link clock");

  // Main scenarios: a valid MII burst, a collision, a realigned group
  c_mii_frame: cover property (@(posedge clock) disable iff (srst)
    rx_nibble_valid [*4]);
  c_collision: cover property (@(posedge clock) disable iff (srst)
    collision_start);
  c_group_seen: cover property (@(posedge clock) disable iff (srst)
    group_valid && group_realigned);
endmodule // mrx_top

// ===== testbench/mrx_phy_model.sv
// Purpose: Behavioural PHY driving the MII status pins or serial receive groups
// Assumes: tx_word is sent again in every group while run is high
// Notes: Lanes toggle when idle so a stale sample can never pass for data
`timescale 1ns/1ps

module mrx_phy_model (
  input wire logic serial_receive_clock,
  input wire logic serial_mode,
  input wire logic run,
  input wire logic [39:0] tx_word,
  input wire logic early_tgl,
  input wire logic mii_valid,
  input wire logic mii_col,
  input wire logic [3:0] mii_nibble,
  output logic port_b_receive_valid,
  output logic port_b_collision_in,
  output logic [3:0] port_b_receive_nibble
);
  logic [3:0] cnt = 4'h0;
  logic early_ack = 1'b0;
  logic sync = 1'b0;
  logic [3:0] lanes = 4'hF;

  always @(posedge serial_receive_clock)
  begin
    if (!run)
    begin
      cnt <= 4'h0;
      sync <= 1'b0;
      lanes <= ~lanes;
    end
    else
    begin
      sync <= (cnt == 4'h0);
      for (int i = 0; i < 4; i++)
        lanes[i] <= tx_word[10 * i + cnt];
      // Early sync on request cuts the group after five bits
      if (cnt == 4'h4 && early_tgl != early_ack)
      begin
        cnt <= 4'h0;
        early_ack <= early_tgl;
      end
      else if (cnt == 4'h9)
        cnt <= 4'h0;
      else
        cnt <= cnt + 4'h1;
    end
  end

  assign port_b_receive_valid = serial_mode ? sync : mii_valid;
  assign port_b_receive_nibble = serial_mode ? lanes : mii_nibble;
  assign port_b_collision_in = mii_col;
endmodule // mrx_phy_model

// ===== testbench/mrx_top_tb_top.sv
// Purpose: Self-checking bench of the MII / serial MII receive status block
// Assumes: Design latencies as handed over: three core edges for MII pins
// Notes: Serial checks look at the last delivered group, since many groups drop
`timescale 1ns/1ps
`include "mrx_consts.svh"

module mrx_top_tb_top;
  import mrx_pkg::*;
  localparam int LIMIT = 3000;
  localparam logic [39:0] WA = 40'hC3_5A96_E10F;
  localparam logic [39:0] WB = 40'h2D_0F6B_1E94;
  logic clock, srst, serial_receive_clock, run, early_tgl, mii_valid, mii_col;
  logic [3:0] mii_nibble, pn, rx_nibble;
  logic pv, pc, rx_nibble_valid, collision, collision_start;
  logic group_valid, group_realigned, seen_realign, group_overrun, seen_overrun;
  logic [39:0] tx_word, group_data, last_data;
  mrx_mode_t port_mode, active_mode;
  int n_mismatch = 0;
  int n_tests = 0;
  int n_grp = 0;
  int cyc = 0;

  mrx_top u_mrx_top (.clock(clock), .srst(srst), .serial_receive_clock(serial_receive_clock),
    .port_mode(port_mode), .port_b_receive_valid(pv), .port_b_collision_in(pc),
    .port_b_receive_nibble(pn), .active_mode(active_mode), .rx_nibble(rx_nibble),
    .rx_nibble_valid(rx_nibble_valid), .collision(collision),
    .collision_start(collision_start), .group_data(group_data), .group_valid(group_valid),
    .group_realigned(group_realigned), .group_overrun(group_overrun));

  mrx_phy_model u_mrx_phy_model (.serial_receive_clock(serial_receive_clock),
    .serial_mode(port_mode == MRX_MODE_SERIAL), .run(run), .tx_word(tx_word),
    .early_tgl(early_tgl), .mii_valid(mii_valid), .mii_col(mii_col),
    .mii_nibble(mii_nibble), .port_b_receive_valid(pv), .port_b_collision_in(pc),
    .port_b_receive_nibble(pn));

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Link clock free runs, offset so its edges never meet the core's
  initial
  begin
    serial_receive_clock = 1'b0;
    #7;
    forever #15 serial_receive_clock = ~serial_receive_clock;
  end

  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (!srst && group_valid === 1'b1)
    begin
      last_data <= group_data;
      n_grp <= n_grp + 1;
      if (group_realigned === 1'b1)
        seen_realign <= 1'b1;
      if (group_overrun === 1'b1)
        seen_overrun <= 1'b1;
    end
    if (cyc == LIMIT)
    begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_vec(input logic [39:0] got, input logic [39:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Held four core edges: the link side needs srst through its own synchroniser
  task automatic do_reset;
    @(posedge clock);
    srst <= 1'b1;
    repeat (4) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    #1;
  endtask

  task automatic mii_test;
    logic [3:0] hv [16];
    logic hd [16];
    logic [3:0] hold;
    hold = 4'h0;
    chk_vec({38'h0, active_mode}, {38'h0, MRX_MODE_MII});
    for (int k = 0; k < 16; k++)
    begin
      @(posedge clock);
      hv[k] = 4'(k * 7 + 3);
      hd[k] = (k % 5 != 3);
      mii_nibble <= hv[k];
      mii_valid <= hd[k];
      #1;
      if (k >= 3)
      begin
        if (hd[k - 3])
          hold = hv[k - 3];
        chk_bit(rx_nibble_valid, hd[k - 3]);
        chk_vec({36'h0, rx_nibble}, {36'h0, hold});
      end
    end
    mii_valid <= 1'b0;
    $display("test mii_test done");
  endtask

  task automatic col_test;
    @(posedge clock);
    mii_col <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    chk_bit(collision, 1'b1);
    chk_bit(collision_start, 1'b1);
    @(posedge clock);
    #1;
    chk_bit(collision, 1'b1);
    chk_bit(collision_start, 1'b0);
    mii_col <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
    chk_bit(collision, 1'b0);
    $display("test col_test done");
  endtask

  // Collision pin toggles throughout; it must never show in serial mode
  task automatic wait_serial(input int n);
    for (int k = 0; k < n; k++)
    begin
      @(posedge clock);
      mii_col <= k[0];
      #1;
      chk_bit(collision, 1'b0);
      chk_bit(collision_start, 1'b0);
      chk_bit(rx_nibble_valid, 1'b0);
    end
  endtask

  task automatic serial_test;
    port_mode <= MRX_MODE_SERIAL;
    do_reset();
    repeat (2) @(posedge clock);
    tx_word <= WA;
    run <= 1'b1;
    wait_serial(16);
    chk_vec({38'h0, active_mode}, {38'h0, MRX_MODE_SERIAL});
    chk_bit(n_grp > 0, 1'b1);
    chk_vec(last_data, WA);
    seen_realign = 1'b0;
    tx_word <= WB;
    wait_serial(16);
    chk_vec(last_data, WB);
    chk_bit(seen_realign, 1'b0);
    // A hand-off outlasts one 300 ns group here, so drops must have been reported
    chk_bit(seen_overrun, 1'b1);
    early_tgl <= ~early_tgl;
    wait_serial(16);
    chk_bit(seen_realign, 1'b1);
    chk_vec(last_data, WB);
    $display("test serial_test done");
  endtask

  task automatic stop_test;
    $display("counts: tests=%0d mismatches=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    srst = 1'b1;
    run = 1'b0;
    early_tgl = 1'b0;
    mii_valid = 1'b0;
    mii_col = 1'b0;
    mii_nibble = 4'h0;
    tx_word = 40'h0;
    seen_realign = 1'b0;
    seen_overrun = 1'b0;
    last_data = 40'h0;
    port_mode = MRX_MODE_MII;
    do_reset();
    mii_test();
    col_test();
    serial_test();
    stop_test();
  end
endmodule // mrx_top_tb_top
